// ==== shared/acsr_pkg.sv ====
// Constants and types for the converter control and serial readout block
package acsr_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int CLK_PERIOD_NS  = 5;     // Internal clock period
  localparam int CONV_TIME_NS   = 7500;  // Longest acquisition plus conversion
  localparam int CS_HIGH_MIN_NS = 50;    // Least convert_start high time
  localparam int SCLK_PERIOD_NS = 200;   // Least serial clock period (5MHz)
  localparam int CONV_CYC       = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int CS_HIGH_CYC    = (CS_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_MARGIN    = 10;    // Cycles lost in pin synchronisers
  localparam int ACQ_STEPS      = 2;     // Acquisition length in step units
  localparam int STEP_CYC       = (CONV_CYC - SYNC_MARGIN) / (ACQ_STEPS + 8);
  localparam int ACQ_CYC        = ACQ_STEPS * STEP_CYC;
  localparam int RUN_CYC        = ACQ_CYC + 8 * STEP_CYC;

  // ==========================================================================
  // Widths and reset values
  localparam int          RES_W      = 8;      // Result width
  localparam int          ECNT_W     = 4;      // Serial edge counter width
  localparam int          TCNT_W     = 11;     // Step timer width
  localparam logic [7:0]  RESULT_RST = 8'h00;
  localparam logic [7:0]  TRIAL_MSB  = 8'h80;
  localparam logic [3:0]  ECNT_RST   = 4'h0;
  localparam logic [3:0]  LAST_RISE  = 4'h8;   // Rising edge that ends readout
  localparam logic [3:0]  LAST_BIT   = 4'h7;

  // ==========================================================================
  // Conversion state, Gray coded along sleep -> acquire -> approximate
  typedef enum logic [1:0] {
    ACSR_SLEEP = 2'b00,
    ACSR_ACQ   = 2'b01,
    ACSR_SAR   = 2'b11
  } acsr_state_t;

endpackage

// ==== hdl/acsr_top.sv ====
// Converter control, successive approximation and serial readout
`timescale 1ns/100ps
`default_nettype none

module acsr_top #(
  parameter int RES_W = acsr_pkg::RES_W
) (
  // Internal clock and reset
  input  wire logic             CLK,
  input  wire logic             RESETN,
  // Link: convert start, serial clock, data pin
  input  wire logic             CONVERT_START,
  input  wire logic             SCLK,
  output logic                  DOUT_O,
  output logic                  DOUT_OE,
  // Analog front end
  input  wire logic [RES_W-1:0] ANALOG_CODE,
  input  wire logic [RES_W-1:0] MIDSUPPLY_CODE,
  output logic                  ANALOG_POWER,
  output logic                  MID_SELECT
);

  // ==========================================================================
  // Serial clock domain: free-running Gray edge counters
  logic [3:0] rise_bin_r;
  logic [3:0] rise_gray_r;
  logic [3:0] fall_bin_r;
  logic [3:0] fall_gray_r;

  // Rising edges counted, never reset by frames
  always_ff @(posedge SCLK or negedge RESETN) begin
    if (!RESETN) begin
      rise_bin_r  <= acsr_pkg::ECNT_RST;
      rise_gray_r <= acsr_pkg::ECNT_RST;
    end else begin
      rise_bin_r  <= rise_bin_r + 4'h1;
      rise_gray_r <= (rise_bin_r + 4'h1) ^ ((rise_bin_r + 4'h1) >> 1);
    end
  end

  // Falling edges counted the same way
  always_ff @(negedge SCLK or negedge RESETN) begin
    if (!RESETN) begin
      fall_bin_r  <= acsr_pkg::ECNT_RST;
      fall_gray_r <= acsr_pkg::ECNT_RST;
    end else begin
      fall_bin_r  <= fall_bin_r + 4'h1;
      fall_gray_r <= (fall_bin_r + 4'h1) ^ ((fall_bin_r + 4'h1) >> 1);
    end
  end

  // ==========================================================================
  // Crossing of the edge counts into the internal clock domain
  function automatic logic [3:0] gray2bin(input logic [3:0] g);
    logic [3:0] b;
    b[3] = g[3];
    for (int i = 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  logic [3:0] edge_cnt [2];
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_xing
      logic [3:0] s1_r;
      logic [3:0] s2_r;
      logic [3:0] s3_r;
      logic [3:0] acc_r;
      // Three stages; count accepted once stages two and three agree
      always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
          s1_r  <= acsr_pkg::ECNT_RST;
          s2_r  <= acsr_pkg::ECNT_RST;
          s3_r  <= acsr_pkg::ECNT_RST;
          acc_r <= acsr_pkg::ECNT_RST;
        end else begin
          s1_r <= (gi == 0) ? rise_gray_r : fall_gray_r; // Lane 0 rising, lane 1 falling
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r) begin
            acc_r <= gray2bin(s3_r);
          end
        end
      end
      assign edge_cnt[gi] = acc_r;
    end
  endgenerate

  // ==========================================================================
  // Pin synchronisers for convert_start and serial clock level
  logic [2:0] cs_s_r;
  logic       cs_lvl_r;
  logic [2:0] sk_s_r;
  logic       sk_lvl_r;
  logic       cs_fall;

  // Level changes only when second and third stages agree
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      cs_s_r   <= 3'h0;
      cs_lvl_r <= 1'b0;
      sk_s_r   <= 3'h0;
      sk_lvl_r <= 1'b0;
    end else begin
      cs_s_r <= {cs_s_r[1:0], CONVERT_START};
      sk_s_r <= {sk_s_r[1:0], SCLK};
      if (cs_s_r[1] == cs_s_r[2]) begin
        cs_lvl_r <= cs_s_r[2];
      end
      if (sk_s_r[1] == sk_s_r[2]) begin
        sk_lvl_r <= sk_s_r[2];
      end
    end
  end

  // Low level after reset means a pin held low never counts as a fall
  assign cs_fall = cs_lvl_r && !cs_s_r[1] && !cs_s_r[2];

  // ==========================================================================
  // Conversion sequencer on the internal clock
  acsr_pkg::acsr_state_t state_r;
  logic [acsr_pkg::TCNT_W-1:0] tmr_r;
  logic [2:0]                  bit_r;
  logic [RES_W-1:0]            trial_r;
  logic [RES_W-1:0]            trial_nxt;
  logic [RES_W-1:0]            sample_r;
  logic [RES_W-1:0]            result_r;
  logic                        mid_sel_r;
  logic                        done_r;
  logic                        step_end;

  assign step_end = (state_r == acsr_pkg::ACSR_ACQ)
                  ? (tmr_r == acsr_pkg::TCNT_W'(acsr_pkg::ACQ_CYC - 1))
                  : (tmr_r == acsr_pkg::TCNT_W'(acsr_pkg::STEP_CYC - 1));

  // Keep the trial bit when trial does not exceed the held sample
  always_comb begin
    trial_nxt = trial_r;
    if (trial_r > sample_r) begin
      trial_nxt[bit_r] = 1'b0;
    end
    if (bit_r != 3'h0) begin
      trial_nxt[bit_r - 3'h1] = 1'b1;
    end
  end

  // State, timer and approximation steps
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_r <= acsr_pkg::ACSR_SLEEP;
      tmr_r   <= '0;
      bit_r   <= 3'h7;
      trial_r <= acsr_pkg::TRIAL_MSB;
      done_r  <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (cs_fall) begin
        state_r <= acsr_pkg::ACSR_ACQ;
        tmr_r   <= '0;
      end else begin
        case (state_r)
          acsr_pkg::ACSR_SLEEP: begin
            tmr_r <= '0;
          end
          acsr_pkg::ACSR_ACQ: begin
            tmr_r <= tmr_r + 1'b1;
            if (step_end) begin
              state_r <= acsr_pkg::ACSR_SAR;
              tmr_r   <= '0;
              bit_r   <= 3'h7;
              trial_r <= acsr_pkg::TRIAL_MSB;
            end
          end
          acsr_pkg::ACSR_SAR: begin
            tmr_r <= tmr_r + 1'b1;
            if (step_end) begin
              tmr_r   <= '0;
              trial_r <= trial_nxt;
              bit_r   <= bit_r - 3'h1;
              if (bit_r == 3'h0) begin
                state_r <= acsr_pkg::ACSR_SLEEP;
                done_r  <= 1'b1;
              end
            end
          end
          default: begin
            state_r <= acsr_pkg::ACSR_SLEEP;
          end
        endcase
      end
    end
  end

  // Input selection: fall while busy selects mid-supply, idle fall the channel
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      mid_sel_r <= 1'b0;
    end else if (cs_fall) begin
      mid_sel_r <= (state_r != acsr_pkg::ACSR_SLEEP);
    end
  end

  // Sample held at end of acquisition; code is straight binary, LSB = ref/256
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      sample_r <= '0;
    end else if (state_r == acsr_pkg::ACSR_ACQ && step_end && !cs_fall) begin
      sample_r <= mid_sel_r ? MIDSUPPLY_CODE : ANALOG_CODE;
    end
  end

  // Static result register, written only on completion
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      result_r <= acsr_pkg::RESULT_RST;
    end else if (state_r == acsr_pkg::ACSR_SAR && step_end && bit_r == 3'h0 && !cs_fall) begin
      result_r <= trial_nxt;
    end
  end

  // ==========================================================================
  // Readout position tracking
  logic       rd_act_r;
  logic [3:0] base_rise_r;
  logic [3:0] base_fall_r;
  logic       idle_hi_r;
  logic [3:0] rise_diff;
  logic [3:0] fall_diff;
  logic [3:0] idx;
  logic       rd_end;

  assign rise_diff = edge_cnt[0] - base_rise_r;
  assign fall_diff = edge_cnt[1] - base_fall_r;
  assign rd_end    = rd_act_r && (rise_diff >= acsr_pkg::LAST_RISE);

  // Bit index; idle-high master's leading fall does not advance
  always_comb begin
    idx = fall_diff;
    if (idle_hi_r) begin
      idx = (fall_diff == 4'h0) ? 4'h0 : fall_diff - 4'h1;
    end
    if (idx > acsr_pkg::LAST_BIT) begin
      idx = acsr_pkg::LAST_BIT;
    end
  end

  // Edge counts snapshot at completion so earlier edges are ignored
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rd_act_r    <= 1'b0;
      base_rise_r <= acsr_pkg::ECNT_RST;
      base_fall_r <= acsr_pkg::ECNT_RST;
      idle_hi_r   <= 1'b0;
    end else if (cs_fall) begin
      rd_act_r <= 1'b0;
    end else if (done_r) begin
      rd_act_r    <= 1'b1;
      base_rise_r <= edge_cnt[0];
      base_fall_r <= edge_cnt[1];
      idle_hi_r   <= sk_lvl_r;
    end else if (rd_end) begin
      rd_act_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Data pin and status outputs from flops
  logic dout_r;
  logic oe_r;
  logic pwr_r;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      dout_r <= 1'b0;
      oe_r   <= 1'b0;
      pwr_r  <= 1'b0;
    end else begin
      pwr_r <= cs_fall || (state_r != acsr_pkg::ACSR_SLEEP && !done_r);
      if (cs_fall || (state_r != acsr_pkg::ACSR_SLEEP && !done_r)) begin
        oe_r   <= 1'b1;
        dout_r <= 1'b0;
      end else if (done_r || (rd_act_r && !rd_end)) begin
        oe_r   <= 1'b1;
        dout_r <= done_r ? result_r[RES_W-1] : result_r[3'h7 - idx[2:0]]; // No gap before MSB
      end else begin
        oe_r   <= 1'b0;
        dout_r <= 1'b0;
      end
    end
  end

  assign DOUT_O       = dout_r;
  assign DOUT_OE      = oe_r;
  assign ANALOG_POWER = pwr_r;
  assign MID_SELECT   = mid_sel_r;

  // ==========================================================================
  // Checks
  logic [acsr_pkg::TCNT_W:0] run_cnt_r;
  logic                      ever_r;

  // Non-sleep cycles since the last start, and whether any start occurred
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      run_cnt_r <= '0;
      ever_r    <= 1'b0;
    end else if (cs_fall) begin
      run_cnt_r <= '0;
      ever_r    <= 1'b1;
    end else if (state_r != acsr_pkg::ACSR_SLEEP) begin
      run_cnt_r <= run_cnt_r + 1'b1;
    end
  end

  a_fall_starts: assert property (@(posedge CLK) disable iff (!RESETN)
    cs_fall |=> state_r == acsr_pkg::ACSR_ACQ ##1 (DOUT_OE && !DOUT_O))
    else $error("start did not begin acquisition with low output");
  a_dout_low_conv: assert property (@(posedge CLK) disable iff (!RESETN)
    (state_r == acsr_pkg::ACSR_SAR && !cs_fall) |=> (DOUT_OE && !DOUT_O && ANALOG_POWER))
    else $error("output not low while converting");
  a_abort_mid: assert property (@(posedge CLK) disable iff (!RESETN)
    (cs_fall && state_r != acsr_pkg::ACSR_SLEEP) |=> (MID_SELECT && tmr_r == '0))
    else $error("abort did not select mid-supply and restart");
  a_conv_time: assert property (@(posedge CLK) disable iff (!RESETN)
    $rose(done_r) |-> run_cnt_r == (acsr_pkg::TCNT_W+1)'(acsr_pkg::RUN_CYC))
    else $error("conversion length wrong");
  a_msb_first: assert property (@(posedge CLK) disable iff (!RESETN)
    (done_r && !cs_fall) |=> (DOUT_OE && DOUT_O == result_r[7]) ##1 (DOUT_OE && (DOUT_O == result_r[7] || $past(cs_fall))))
    else $error("MSB not presented at completion");
  a_sleep_after: assert property (@(posedge CLK) disable iff (!RESETN)
    (done_r && !cs_fall) |-> (state_r == acsr_pkg::ACSR_SLEEP) ##1 !ANALOG_POWER)
    else $error("no power-down after conversion");
  a_result_static: assert property (@(posedge CLK) disable iff (!RESETN)
    (state_r == acsr_pkg::ACSR_SLEEP && !done_r) |=> $stable(result_r))
    else $error("result changed outside completion");
  a_idle_hiz: assert property (@(posedge CLK) disable iff (!RESETN)
    (!ever_r && !cs_fall) |=> !DOUT_OE)
    else $error("output driven before first start");
  a_release_hold: assert property (@(posedge CLK) disable iff (!RESETN)
    (rd_end && !cs_fall) |=> (!DOUT_OE && !rd_act_r) ##1 (!DOUT_OE || ANALOG_POWER))
    else $error("output not released after readout");

endmodule

`default_nettype wire

// ==== tb/acsr_master.sv ====
// Serial master model: drives convert_start and the serial clock, reads result bytes
`timescale 1ns/100ps
`default_nettype none

module acsr_master (
  // Internal clock for start pulse timing
  input  wire logic       clk,
  // Link
  output logic            convert_start,
  output logic            sclk,
  input  wire logic       dout,
  // Received byte
  output logic [7:0]      byte_o,
  output logic            byte_vld
);
  // ==========================================================================
  // Timing state
  realtime t_fall;
  real     half_ns = 103.3;  // Just under 5MHz, off the internal clock grid

  // Start low at power-up, serial clock idle low
  initial begin
    convert_start = 1'h0;
    sclk          = 1'h0;
    byte_o        = 8'h00;
    byte_vld      = 1'h0;
    t_fall        = 0;
  end

  // ==========================================================================
  // High then low per pulse; a second pulse selects mid-supply
  task automatic convert(input logic mid, input logic idle);
    sclk <= idle;
    for (int p = 0; p <= int'(mid); p++) begin
      @(posedge clk);
      convert_start <= 1'h1;
      repeat (24) @(posedge clk);
      convert_start <= 1'h0;
      t_fall = $realtime;
      repeat (24) @(posedge clk);
    end
  endtask

  // Whole serial clock pulses, returning to idle
  task automatic pulses(input int n, input logic idle);
    for (int i = 0; i < n; i++) begin
      sclk <= ~idle;
      #(half_ns);
      sclk <= idle;
      #(half_ns);
    end
  endtask

  // Wait out the conversion, then clock in eight bits on rising edges
  task automatic read(input logic idle);
    logic [7:0] got;
    #(t_fall + 7601.3 - $realtime);
    for (int i = 0; i < 8; i++) begin
      if (idle) begin
        sclk <= 1'h0;
        #(half_ns);
      end
      got[7-i] = dout;
      sclk <= 1'h1;
      #(half_ns);
      if (!idle) begin
        sclk <= 1'h0;
        #(half_ns);
      end
    end
    byte_o   <= got;
    byte_vld <= 1'h1;
    #(half_ns);
    byte_vld <= 1'h0;
  endtask
endmodule

`default_nettype wire

// ==== tb/adc_convert_serial_readout_tb.sv ====
// Self-checking testbench for the converter control and serial readout block
`timescale 1ns/100ps
`default_nettype none

module adc_convert_serial_readout_tb;
  // ==========================================================================
  // Signals
  logic       clk      = 1'h0;
  logic       resetn   = 1'h0;
  logic [7:0] ana_code = 8'h00;
  logic [7:0] mid_code = 8'h00;
  wire logic  cs;
  wire logic  sclk;
  wire logic  dout_o;
  wire logic  dout_oe;
  wire logic  power;
  wire logic  mid_sel;
  wire logic [7:0] byte_o;
  wire logic  byte_vld;
  wire logic  dout_w = dout_oe ? dout_o : 1'bz;  // Pin resolved from enable
  int         n_fail   = 0;
  int         compares = 0;
  logic [7:0] exp_q[$];

  // Internal clock, 200MHz
  always #2.5 clk = ~clk;

  // ==========================================================================
  // Instances
  acsr_top u_dut (
    .CLK            (clk),
    .RESETN         (resetn),
    .CONVERT_START  (cs),
    .SCLK           (sclk),
    .DOUT_O         (dout_o),
    .DOUT_OE        (dout_oe),
    .ANALOG_CODE    (ana_code),
    .MIDSUPPLY_CODE (mid_code),
    .ANALOG_POWER   (power),
    .MID_SELECT     (mid_sel)
  );

  acsr_master u_mst (
    .clk           (clk),
    .convert_start (cs),
    .sclk          (sclk),
    .dout          (dout_w),
    .byte_o        (byte_o),
    .byte_vld      (byte_vld)
  );

  // ==========================================================================
  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Verdict and end of run
  task automatic wrap_up();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Received bytes against the oldest note
  always @(posedge byte_vld) begin
    if (exp_q.size() == 0) chk(8'h01, 8'h00, "unexpected byte");
    else chk(byte_o, exp_q.pop_front(), "result byte");
  end

  // One conversion and readout, channel or mid-supply, idle low or high
  task automatic run(input logic mid, input logic idle);
    @(posedge clk);
    ana_code <= 8'($urandom);
    mid_code <= 8'($urandom);
    @(posedge clk);
    exp_q.push_back(mid ? mid_code : ana_code);
    u_mst.convert(mid, idle);
    #1;
    chk(8'(dout_oe), 8'h01, "driven in conversion");
    chk(8'(dout_o), 8'h00, "low in conversion");
    chk(8'(power), 8'h01, "powered in conversion");
    u_mst.pulses(4, idle);
    chk(8'(dout_o), 8'h00, "serial clock ignored");
    u_mst.read(idle);
    chk(8'(power), 8'h00, "powered down");
    chk(8'(mid_sel), 8'(mid), "input selection");
    repeat (60) @(posedge clk);
    #1;
    chk(8'(dout_oe), 8'h00, "released after eighth rise");
    u_mst.pulses(3, idle);
    chk(8'(dout_oe), 8'h00, "edges after release");
    $display("test mid=%0d idle=%0d done", mid, idle);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    void'($urandom(54435));
    repeat (16) @(posedge clk);
    resetn <= 1'h1;
    repeat (40) @(posedge clk);
    #1;
    chk(8'(dout_oe), 8'h00, "no start at power-up");
    chk(8'(power), 8'h00, "asleep at power-up");
    $display("test power-up done");
    for (int t = 0; t < 6; t++) begin
      run(t[0], t[1]);
    end
    wrap_up();
  end

  // Watchdog
  initial begin
    #150000;
    n_fail++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule

`default_nettype wire
